// File: sws_params.svh
`ifndef SWS_PARAMS_SVH
`define SWS_PARAMS_SVH
// frame and field layout
`define SWS_FRAME_BITS 16
`define SWS_CMD_MASK 8'hFC
`define SWS_CMD_WR_STATE 8'h98
`define SWS_CMD_RD_STATE 8'h94
`define SWS_CMD_WR_SRC 8'hA8
`define SWS_CMD_RD_SRC 8'hA4
`define SWS_CMD_RD_FAULT 8'h80
`define SWS_ADDR_MATCH 2'h2
`define SWS_REG_RESET 8'hFF
`define SWS_FAULT_OK 2'h3
`define SWS_FAULT_RESET 12'hFFF
// host side: link clock divider, half period in sys_clk cycles
`define SWS_BAUD_MAX_HZ 5000000
`define SWS_SYS_HZ 200000000
`define SWS_HALF_CYC (`SWS_SYS_HZ / `SWS_BAUD_MAX_HZ / 2)
`define SWS_CS_GAP_CYC 8
// apb map of the host controller
`define SWS_APB_CTRL 12'h000
`define SWS_APB_TXD 12'h004
`define SWS_APB_RXD 12'h008
`define SWS_APB_STAT 12'h00C
`endif

// File: sws_pkg.sv
package sws_pkg;
	typedef enum logic [1:0] {SWS_IDLE, SWS_ADDR, SWS_BODY, SWS_SKIP} sws_dev_e;
	typedef enum logic [1:0] {SWS_H_IDLE, SWS_H_LEAD, SWS_H_SHIFT, SWS_H_LAG} sws_host_e;
endpackage : sws_pkg

// File: sws_link_if.sv
`timescale 1ns/10ps
interface sws_link_if;
	logic cs_n;
	logic sclk;
	logic si;
	logic so_o;
	logic so_oe;
	logic rst_n;
	wire so = so_oe ? so_o : 1'b1;
	modport device (input cs_n, input sclk, input si, input rst_n,
		output so_o, output so_oe);
	modport host (output cs_n, output sclk, output si, output rst_n,
		input so, input so_oe);
endinterface : sws_link_if

// File: sws_device.sv
`timescale 1ns/10ps
`include "sws_params.svh"
module sws_device (
	// system
	input wire logic sys_clk,
	input wire logic srst,
	// link
	sws_link_if.device link,
	// power stage side
	input wire logic [5:0] direct_drive_pads,
	input wire logic parallel_active_high,
	input wire logic undervoltage,
	input wire logic [11:0] channel_fault_code,
	input wire logic [5:0] overtemp_flag,
	output logic [5:0] stage_on,
	output logic [7:0] drive_source_select_reg,
	output logic [7:0] serial_drive_state_reg
);
	logic [2:0] cs_sy_q, ck_sy_q, si_sy_q, rs_sy_q;
	logic cs_q, ck_q, si_q, rs_q;
	logic [11:0] fault_q;
	logic ot_q;
	logic [7:0] src_q, st_q;
	logic [15:0] rx_q, tx_q;
	logic [5:0] cnt_q;
	logic so_q, oe_q;
	sws_pkg::sws_dev_e st_e_q;
	logic cs_fall, cs_rise, ck_fall, ck_rise, hard_rst, any_fault;
	logic [7:0] cmd;
	logic [7:0] cmd_now;
	logic [6:0] pin_a_q, pin_b_q, pin_c_q, pin_q;

	// three-stage synchronisers; filtered level when stages 2,3 agree
	always_ff @(posedge sys_clk) begin
		cs_sy_q <= {cs_sy_q[1:0], link.cs_n};
		ck_sy_q <= {ck_sy_q[1:0], link.sclk};
		si_sy_q <= {si_sy_q[1:0], link.si};
		rs_sy_q <= {rs_sy_q[1:0], link.rst_n};
		if (srst) begin
			cs_sy_q <= 3'h7;
			ck_sy_q <= 3'h0;
			si_sy_q <= 3'h0;
			rs_sy_q <= 3'h7;
		end
	end
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			cs_q <= 1'b1;
			ck_q <= 1'b0;
			si_q <= 1'b0;
			rs_q <= 1'b1;
		end else begin
			if (cs_sy_q[1] == cs_sy_q[2]) cs_q <= cs_sy_q[2];
			if (ck_sy_q[1] == ck_sy_q[2]) ck_q <= ck_sy_q[2];
			if (si_sy_q[1] == si_sy_q[2]) si_q <= si_sy_q[2];
			if (rs_sy_q[1] == rs_sy_q[2]) rs_q <= rs_sy_q[2];
		end
	end

	assign hard_rst = srst || !rs_q || undervoltage;
	assign cs_fall = cs_q && (cs_sy_q[1] == cs_sy_q[2]) && !cs_sy_q[2];
	assign cs_rise = !cs_q && (cs_sy_q[1] == cs_sy_q[2]) && cs_sy_q[2];
	// edges only while selected; sclk comes from the master
	assign ck_fall = !cs_q && ck_q && (ck_sy_q[1] == ck_sy_q[2])
		&& !ck_sy_q[2];
	assign ck_rise = !cs_q && !ck_q && (ck_sy_q[1] == ck_sy_q[2])
		&& ck_sy_q[2];
	assign cmd = rx_q[15:8] & `SWS_CMD_MASK;
	// control byte as it stands after eight falls, before the data byte
	assign cmd_now = rx_q[7:0] & `SWS_CMD_MASK;
	assign any_fault = (fault_q != `SWS_FAULT_RESET) || ot_q;

	// fault latch: hold a fault until readout; new events win over clear
	always_ff @(posedge sys_clk) begin
		if (hard_rst) begin
			fault_q <= `SWS_FAULT_RESET;
			ot_q <= 1'b0;
		end else begin
			for (int i = 0; i < 6; i++) begin
				if (cs_rise && cnt_q == 6'(`SWS_FRAME_BITS)
					&& st_e_q == sws_pkg::SWS_BODY
					&& cmd == `SWS_CMD_RD_FAULT)
					fault_q[2*i +: 2] <= `SWS_FAULT_OK;
				if (channel_fault_code[2*i +: 2] != `SWS_FAULT_OK)
					fault_q[2*i +: 2] <= channel_fault_code[2*i +: 2];
			end
			if (cs_rise && cnt_q == 6'(`SWS_FRAME_BITS)
				&& st_e_q == sws_pkg::SWS_BODY && cmd == `SWS_CMD_RD_FAULT)
				ot_q <= 1'b0;
			if (|overtemp_flag) ot_q <= 1'b1;
		end
	end

	// atomic register commit at cs rise
	always_ff @(posedge sys_clk) begin
		if (hard_rst) begin
			src_q <= `SWS_REG_RESET;
			st_q <= `SWS_REG_RESET;
		end else if (cs_rise && cnt_q == 6'(`SWS_FRAME_BITS)
			&& st_e_q == sws_pkg::SWS_BODY) begin
			if (cmd == `SWS_CMD_WR_STATE)
				st_q <= {rx_q[7:2], 2'h3};
			if (cmd == `SWS_CMD_WR_SRC)
				src_q <= {rx_q[7:2], 2'h3};
		end
	end

	// frame state machine
	always_ff @(posedge sys_clk) begin
		if (hard_rst || cs_q) begin
			st_e_q <= sws_pkg::SWS_IDLE;
		end else begin
			unique case (st_e_q)
				sws_pkg::SWS_IDLE: st_e_q <= sws_pkg::SWS_ADDR;
				sws_pkg::SWS_ADDR: begin
					if (ck_fall && cnt_q == 6'd1) begin
						if ({rx_q[0], si_q} == `SWS_ADDR_MATCH)
							st_e_q <= sws_pkg::SWS_BODY;
						else
							st_e_q <= sws_pkg::SWS_SKIP;
					end
				end
				sws_pkg::SWS_BODY: st_e_q <= sws_pkg::SWS_BODY;
				sws_pkg::SWS_SKIP: st_e_q <= sws_pkg::SWS_SKIP;
			endcase
		end
	end

	// receive shifter, msb first, counts falling edges
	always_ff @(posedge sys_clk) begin
		if (hard_rst) begin
			rx_q <= 16'h0000;
			cnt_q <= 6'h00;
		end else if (cs_fall) begin
			cnt_q <= 6'h00;
		end else if (ck_fall) begin
			rx_q <= {rx_q[14:0], si_q};
			if (cnt_q != 6'h3F) cnt_q <= cnt_q + 6'h01;
		end
	end

	// transmit shifter: first byte loads at cs fall, second after cmd
	always_ff @(posedge sys_clk) begin
		if (hard_rst) begin
			tx_q <= 16'hFFFF;
			so_q <= 1'b1;
		end else if (cs_fall) begin
			tx_q <= {2'h3, any_fault, ot_q, fault_q};
			so_q <= 1'b1;
		end else if (ck_rise) begin
			// second byte replaces the low half, index keeps counting
			if (cnt_q == 6'd8) begin
				unique case (cmd_now)
					`SWS_CMD_RD_STATE: begin
						so_q <= st_q[7];
						tx_q[7:0] <= st_q;
					end
					`SWS_CMD_RD_SRC: begin
						so_q <= src_q[7];
						tx_q[7:0] <= src_q;
					end
					default: so_q <= tx_q[7];
				endcase
			end else begin
				so_q <= tx_q[15 - cnt_q[3:0]];
			end
		end
	end

	// so enabled only once addressed
	always_ff @(posedge sys_clk) begin
		if (hard_rst || cs_q)
			oe_q <= 1'b0;
		else
			oe_q <= (st_e_q == sws_pkg::SWS_BODY);
	end
	assign link.so_o = so_q;
	assign link.so_oe = oe_q;

	// pads and strap pin pass three flops like the link pins
	always_ff @(posedge sys_clk) begin
		pin_a_q <= {parallel_active_high, direct_drive_pads};
		pin_b_q <= pin_a_q;
		pin_c_q <= pin_b_q;
	end
	// reset value: high-active strap with pads low keeps stages off
	always_ff @(posedge sys_clk) begin
		if (srst)
			pin_q <= 7'h40;
		else
			for (int i = 0; i < 7; i++)
				if (pin_b_q[i] == pin_c_q[i]) pin_q[i] <= pin_c_q[i];
	end

	// stage control: state low = on, source high = parallel
	always_ff @(posedge sys_clk) begin
		if (hard_rst)
			stage_on <= 6'h00;
		else
			for (int i = 0; i < 6; i++)
				stage_on[i] <= src_q[i+2]
					? (pin_q[i] == pin_q[6])
					: !st_q[i+2];
	end
	assign drive_source_select_reg = src_q;
	assign serial_drive_state_reg = st_q;
endmodule : sws_device

// File: sws_host.sv
`timescale 1ns/10ps
`include "sws_params.svh"
module sws_host (
	// system
	input wire logic sys_clk,
	input wire logic srst,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// link
	sws_link_if.host link
);
	logic [15:0] txd_q, sh_q, rxd_q;
	logic [31:0] rd_word;
	logic so_f_q;
	logic [4:0] bits_q;
	logic [4:0] nbits_q;
	logic [7:0] div_q;
	logic busy_q, done_q, rst_q, ck_q, cs_q, si_q;
	logic [2:0] so_sy_q;
	sws_pkg::sws_host_e st_q;
	logic wr, start;

	assign wr = psel && penable && pwrite;
	assign start = wr && paddr == `SWS_APB_CTRL && pwdata[0] && !busy_q;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !(paddr == `SWS_APB_CTRL
		|| paddr == `SWS_APB_TXD || paddr == `SWS_APB_RXD
		|| paddr == `SWS_APB_STAT);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			txd_q <= 16'h0000;
			rst_q <= 1'b1;
			nbits_q <= 5'd16;
		end else if (wr) begin
			if (paddr == `SWS_APB_TXD) txd_q <= pwdata[15:0];
			if (paddr == `SWS_APB_CTRL) begin
				rst_q <= !pwdata[1];
				if (pwdata[12:8] != 5'h00) nbits_q <= pwdata[12:8];
			end
		end
	end

	always_comb begin
		rd_word = 32'h0000_0000;
		unique case (paddr)
			`SWS_APB_CTRL: rd_word = {19'h0, nbits_q, 6'h0, !rst_q, 1'b0};
			`SWS_APB_TXD: rd_word = {16'h0, txd_q};
			`SWS_APB_RXD: rd_word = {16'h0, rxd_q};
			`SWS_APB_STAT: rd_word = {30'h0, done_q, busy_q};
			default: rd_word = 32'h0000_0000;
		endcase
	end

	// read data registered in the setup phase, stands through access
	always_ff @(posedge sys_clk) begin
		if (srst)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= rd_word;
	end

	// so through three flops; taken once stages two and three agree
	always_ff @(posedge sys_clk) begin
		so_sy_q <= {so_sy_q[1:0], link.so};
		if (so_sy_q[1] == so_sy_q[2]) so_f_q <= so_sy_q[2];
		if (srst) begin
			so_sy_q <= 3'h7;
			so_f_q <= 1'b1;
		end
	end

	// sclk held low at cs edges; msb first
	// half-period divider keeps sclk at most 5 MHz
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q <= sws_pkg::SWS_H_IDLE;
			cs_q <= 1'b1;
			ck_q <= 1'b0;
			si_q <= 1'b0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			div_q <= 8'h00;
			bits_q <= 5'h00;
			sh_q <= 16'h0000;
			rxd_q <= 16'h0000;
		end else begin
			if (wr && paddr == `SWS_APB_STAT && pwdata[1]) done_q <= 1'b0;
			div_q <= (div_q == 8'h00) ? 8'h00 : div_q - 8'h01;
			unique case (st_q)
				sws_pkg::SWS_H_IDLE: if (start) begin
					busy_q <= 1'b1;
					cs_q <= 1'b0;
					sh_q <= txd_q;
					bits_q <= 5'h00;
					div_q <= 8'(`SWS_HALF_CYC);
					st_q <= sws_pkg::SWS_H_LEAD;
				end
				sws_pkg::SWS_H_LEAD: if (div_q == 8'h00) begin
					ck_q <= 1'b1;
					si_q <= sh_q[15];
					div_q <= 8'(`SWS_HALF_CYC);
					st_q <= sws_pkg::SWS_H_SHIFT;
				end
				sws_pkg::SWS_H_SHIFT: if (div_q == 8'h00) begin
					div_q <= 8'(`SWS_HALF_CYC);
					if (ck_q) begin
						ck_q <= 1'b0;
						sh_q <= {sh_q[14:0], so_f_q};
						bits_q <= bits_q + 5'h01;
						if (bits_q + 5'h01 == nbits_q)
							st_q <= sws_pkg::SWS_H_LAG;
					end else begin
						ck_q <= 1'b1;
						si_q <= sh_q[15];
					end
				end
				// cs rises a half period after the last fall
				sws_pkg::SWS_H_LAG: if (div_q == 8'h00) begin
					if (!cs_q) begin
						cs_q <= 1'b1;
						rxd_q <= sh_q;
						div_q <= 8'(`SWS_CS_GAP_CYC * `SWS_HALF_CYC);
					end else begin
						busy_q <= 1'b0;
						done_q <= 1'b1;
						st_q <= sws_pkg::SWS_H_IDLE;
					end
				end
			endcase
		end
	end
	assign link.cs_n = cs_q;
	assign link.sclk = ck_q;
	assign link.si = si_q;
	assign link.rst_n = rst_q;
endmodule : sws_host

// File: sws_link_sva.sv
`timescale 1ns/10ps
module sws_link_sva (
	// system
	input wire logic sys_clk,
	input wire logic srst,
	// link
	input wire logic cs_n,
	input wire logic sclk,
	input wire logic si,
	input wire logic so_o,
	input wire logic so_oe,
	input wire logic rst_n
);
	logic sclk_q;
	logic cs_q;
	logic [4:0] nfall_q;
	logic [1:0] first2_q;
	wire fall = sclk_q && !sclk;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	always_ff @(posedge sys_clk) begin
		sclk_q <= sclk;
		cs_q <= cs_n;
	end
	// falling sclk edges since the last cs fall
	always_ff @(posedge sys_clk) begin
		if (srst || (cs_q && !cs_n))
			nfall_q <= 5'h00;
		else if (fall && nfall_q != 5'h1F)
			nfall_q <= nfall_q + 5'h01;
	end
	always_ff @(posedge sys_clk) begin
		if (srst)
			first2_q <= 2'h0;
		else if (fall && nfall_q < 5'h02)
			first2_q <= {first2_q[0], si};
	end
	sequence s_cs_edge;
		$changed(cs_n);
	endsequence
	sequence s_low8;
		(!sclk) [*8];
	endsequence
	a_cs_clk_low: assert property (s_cs_edge |-> !sclk && !$past(sclk))
		else $error("cs edge with sclk high");
	a_lead_time: assert property ($fell(cs_n) |-> s_low8)
		else $error("sclk rose too soon after cs fall");
	a_idle_clk: assert property (cs_n |-> !sclk)
		else $error("sclk high while cs high");
	a_high_time: assert property ($rose(sclk) |-> sclk [*8])
		else $error("sclk high phase too short");
	a_low_time: assert property ($fell(sclk) |-> s_low8)
		else $error("sclk low phase too short");
	a_cs_high_z: assert property (cs_n [*8] |-> !so_oe)
		else $error("so driven while cs high");
	a_addr_bits_z: assert property (so_oe |-> nfall_q >= 5'h02)
		else $error("so driven during address bits");
	a_addr_reject: assert property ((nfall_q >= 5'h02 &&
		first2_q != 2'h2) |-> !so_oe)
		else $error("so driven when not addressed");
	a_addr_drive: assert property ((nfall_q == 5'h03 &&
		first2_q == 2'h2 && !cs_n && rst_n) |-> so_oe)
		else $error("so not driven when addressed");
	a_so_rise_only: assert property ((!cs_n && !sclk) [*8] |-> $stable(so_o))
		else $error("so changed while sclk low");
	a_reset_z: assert property ((!rst_n) [*8] |-> !so_oe)
		else $error("so driven during link reset");
endmodule : sws_link_sva

// File: six_channel_switch_spi_slave_tb.sv
`timescale 1ns/10ps
`include "sws_params.svh"
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_errors++; \
$display("unexpected at %0t: got %h want %h", $time, g, e); end end
module six_channel_switch_spi_slave_tb;
	logic sys_clk = 1'h0;
	logic srst = 1'h1;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [5:0] pads = 6'h00;
	logic hi_act = 1'h1;
	logic uv = 1'h0;
	logic [11:0] fcode = 12'hFFF;
	logic [5:0] ot = 6'h00;
	logic [5:0] stage_on;
	logic [7:0] src;
	logic [7:0] st;
	logic [31:0] rdat;
	logic rerr;
	logic [15:0] rx;
	logic [7:0] bad [3] = '{8'h58, 8'hD8, 8'h18};
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	sws_link_if link_if ();
	sws_host sws_host_inst (.sys_clk, .srst, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .link(link_if));
	sws_device sws_device_inst (.sys_clk, .srst, .link(link_if),
		.direct_drive_pads(pads), .parallel_active_high(hi_act),
		.undervoltage(uv), .channel_fault_code(fcode), .overtemp_flag(ot),
		.stage_on, .drive_source_select_reg(src),
		.serial_drive_state_reg(st));
	sws_link_sva sws_link_sva_inst (.sys_clk, .srst, .cs_n(link_if.cs_n),
		.sclk(link_if.sclk), .si(link_if.si), .so_o(link_if.so_o),
		.so_oe(link_if.so_oe), .rst_n(link_if.rst_n));
	always #2.5 sys_clk = ~sys_clk;
	task final_report;
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : final_report
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_errors++;
			final_report();
		end
	end
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'h1;
		@(posedge sys_clk);
		while (pready !== 1'h1)
			@(posedge sys_clk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge sys_clk);
	endtask : apb
	// one transfer of nb sclk periods through the host, received word left in rx
	task automatic frame(input logic [15:0] f, input logic [4:0] nb);
		apb(1'h1, `SWS_APB_TXD, {16'h0000, f});
		apb(1'h1, `SWS_APB_CTRL, {19'h0_0000, nb, 8'h01});
		apb(1'h0, `SWS_APB_STAT, 32'h0000_0000);
		while (rdat[1] !== 1'h1)
			apb(1'h0, `SWS_APB_STAT, 32'h0000_0000);
		apb(1'h1, `SWS_APB_STAT, 32'h0000_0002);
		apb(1'h0, `SWS_APB_RXD, 32'h0000_0000);
		rx = rdat[15:0];
	endtask : frame
	initial begin
		repeat (12) @(posedge sys_clk);
		srst <= 1'h0;
		@(posedge sys_clk);
		`CHK(src, 8'hFF)
		`CHK(stage_on, 6'h00)
		frame(16'h9854, 5'h10);
		`CHK(rx, 16'hCFFF)
		`CHK(st, 8'h57)
		frame(16'hA830, 5'h10);
		`CHK(src, 8'h33)
		`CHK(stage_on, 6'h22)
		frame(16'h94FF, 5'h10);
		`CHK(rx, 16'hCF57)
		frame(16'hA400, 5'h10);
		`CHK(rx, 16'hCF33)
		for (int i = 0; i < 2; i++) begin
			frame(16'h9800, i ? 5'h11 : 5'h0F);
			`CHK(st, 8'h57)
		end
		foreach (bad[i]) begin
			frame({bad[i], 8'h00}, 5'h10);
			`CHK(rx, 16'hFFFF)
			`CHK(st, 8'h57)
		end
		pads <= 6'h08;
		fcode <= 12'hFF3;
		ot <= 6'h01;
		repeat (8) @(posedge sys_clk);
		fcode <= 12'hFFF;
		ot <= 6'h00;
		repeat (8) @(posedge sys_clk);
		frame(16'hBC00, 5'h10);
		`CHK(rx, 16'hFFF3)
		`CHK(st, 8'h57)
		`CHK(stage_on, 6'h2A)
		hi_act <= 1'h0;
		frame(16'h8000, 5'h10);
		`CHK(rx, 16'hFFF3)
		`CHK(stage_on, 6'h26)
		frame(16'h8000, 5'h10);
		`CHK(rx, 16'hCFFF)
		apb(1'h1, `SWS_APB_CTRL, 32'h0000_0002);
		repeat (8) @(posedge sys_clk);
		`CHK(stage_on, 6'h00)
		apb(1'h1, `SWS_APB_CTRL, 32'h0000_0000);
		repeat (8) @(posedge sys_clk);
		`CHK(st, 8'hFF)
		frame(16'hA800, 5'h10);
		`CHK(src, 8'h03)
		uv <= 1'h1;
		repeat (8) @(posedge sys_clk);
		`CHK(stage_on, 6'h00)
		uv <= 1'h0;
		repeat (8) @(posedge sys_clk);
		`CHK(src, 8'hFF)
		apb(1'h0, 12'h010, 32'h0000_0000);
		`CHK(rerr, 1'h1)
		final_report();
	end
endmodule : six_channel_switch_spi_slave_tb
